/* hw/tcr_regs.sv */
// APB register bank of the sub-GHz transceiver with its data FIFO
`timescale 1ns/1ps
// How it works
// - Mode field bits 2:0 picks sleep to receive; 110/111 reserved; resets standby
// - Keying field bits 6:5: 00 frequency shift, 01 on-off, others reserved
// - Frequency shift shaping bits 4:3: none, Gaussian BT 1.0, 0.5, 0.3
// - On-off shaping: none, cutoff rate, cutoff twice rate, 11 reserved
// - Rate is crystal over divider word plus fraction sixteenths
// - Divider bytes reset to 0x1A and 0x0B, 4.8 kb/s
// - Fraction of the divider lives at index 0x70
// - Deviation is 14 bits: six high at bits 5:0, eight low
// - Index 0x00 is the FIFO port: write pushes except in receive mode, read pops except in transmit mode
// - Every register takes its built-in value at power-on reset
// - Index 0x42 returns a read-only silicon revision
// - Fields are readable, writable, trigger or write-one-to-clear
// - 0x40 routes pins zero to three; 0x41 pins four, five, clock out
// - 0x3E shows lock, timeout, RSSI; 0x3F FIFO flags, low battery
// - 0x6C holds temperature caught at the last calibration
// - New carrier applies only on synth mode entry or receiver restart
module tcr_regs #(
  parameter int FIFO_DEPTH = 16,
  parameter logic [7:0] REVISION = tcr_pkg::REVISION_DEFAULT
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcr_pkg::ADDR_W-1:0] paddr,
  input wire logic [tcr_pkg::DATA_W-1:0] pwdata,
  output logic [tcr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Radio status and FIFO side
  input wire tcr_pkg::tcr_radio_s radio,
  input wire logic radio_push,
  input wire logic [7:0] radio_wdata,
  input wire logic radio_pop,
  output logic [7:0] radio_rdata_reg,
  // Configuration and interrupt
  output tcr_pkg::tcr_cfg_s cfg_reg,
  output logic irq_reg
);

  localparam int AW = $clog2(FIFO_DEPTH);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [7:0] idx;
  logic aligned;
  logic done;
  logic wr;
  logic rd;
  logic [7:0] wb;
  assign idx = paddr[tcr_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == tcr_pkg::WORD_ALIGN);
  assign done = psel & penable & pready;
  assign wr = done & pwrite & aligned;
  assign rd = done & ~pwrite & aligned;
  assign wb = pwdata[7:0];

  function automatic logic is_mapped(input logic [7:0] i);
    case (i)
      tcr_pkg::IDX_FIFO, tcr_pkg::IDX_OPMODE, tcr_pkg::IDX_RATE_HI,
      tcr_pkg::IDX_RATE_LO, tcr_pkg::IDX_DEV_HI, tcr_pkg::IDX_DEV_LO,
      tcr_pkg::IDX_CARRIER_HI, tcr_pkg::IDX_CARRIER_MID,
      tcr_pkg::IDX_CARRIER_LO, tcr_pkg::IDX_FLAGS_ONE,
      tcr_pkg::IDX_FLAGS_TWO, tcr_pkg::IDX_PIN_ONE, tcr_pkg::IDX_PIN_TWO,
      tcr_pkg::IDX_REVISION, tcr_pkg::IDX_GAIN_REF, tcr_pkg::IDX_GAIN_TH1,
      tcr_pkg::IDX_GAIN_TH2, tcr_pkg::IDX_GAIN_TH3, tcr_pkg::IDX_HOP,
      tcr_pkg::IDX_REF_SEL, tcr_pkg::IDX_AMP_HP, tcr_pkg::IDX_LOOP_BW,
      tcr_pkg::IDX_QUIET_BW, tcr_pkg::IDX_CAL_TEMP, tcr_pkg::IDX_FRACTION,
      tcr_pkg::IDX_EV_STATUS, tcr_pkg::IDX_EV_CLEAR,
      tcr_pkg::IDX_EV_ENABLE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic wr_at(input logic [7:0] i);
    wr_at = wr & (idx == i);
  endfunction

  // ----------------------------------------
  // Data FIFO
  // ----------------------------------------
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic fifo_full;
  logic fifo_empty;
  logic push_req;
  logic pop_req;
  logic push_ok;
  logic pop_ok;
  logic in_rx;
  logic in_tx;
  assign fifo_full = (count_reg == (AW+1)'(FIFO_DEPTH));
  assign fifo_empty = (count_reg == '0);
  assign in_rx = (cfg_reg.mode == tcr_pkg::MODE_RX);
  assign in_tx = (cfg_reg.mode == tcr_pkg::MODE_TX);
  // Receiver fills in receive mode, transmitter drains in transmit mode
  assign push_req = in_rx ? radio_push : wr_at(tcr_pkg::IDX_FIFO);
  assign pop_req = in_tx ? radio_pop : rd & (idx == tcr_pkg::IDX_FIFO);
  assign push_ok = push_req & ~fifo_full;
  assign pop_ok = pop_req & ~fifo_empty;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(FIFO_DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge pclk) begin
    if (push_ok) begin
      fifo_mem[wptr_reg] <= in_rx ? radio_wdata : wb;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push_ok) begin
        wptr_reg <= ptr_inc(wptr_reg);
      end
      if (pop_ok) begin
        rptr_reg <= ptr_inc(rptr_reg);
      end
      case ({push_ok, pop_ok})
        2'h2: count_reg <= count_reg + (AW+1)'(1);
        2'h1: count_reg <= count_reg - (AW+1)'(1);
        default: count_reg <= count_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      radio_rdata_reg <= tcr_pkg::RST_ZERO;
    end else if (in_tx & pop_ok) begin
      radio_rdata_reg <= fifo_mem[rptr_reg];
    end
  end

  // ----------------------------------------
  // Common settings
  // ----------------------------------------
  logic [2:0] mode_w;
  logic [1:0] key_w;
  logic [1:0] shape_w;
  logic mode_ok;
  logic key_ok;
  logic shape_ok;
  assign mode_w = wb[tcr_pkg::MODE_LSB +: 3];
  assign key_w = wb[tcr_pkg::KEY_LSB +: 2];
  assign shape_w = wb[tcr_pkg::SHAPE_LSB +: 2];
  assign mode_ok = (mode_w <= tcr_pkg::MODE_RX);
  assign key_ok = (key_w == tcr_pkg::KEY_FSK) |
                  (key_w == tcr_pkg::KEY_OOK);
  // All four FSK shapings exist; OOK code 11 is refused
  assign shape_ok = (key_w == tcr_pkg::KEY_FSK) |
                    (shape_w != tcr_pkg::SHAPE_RSVD_OOK);

  // Carrier staging registers and other plain settings
  logic [7:0] car_hi_reg;
  logic [7:0] car_mid_reg;
  logic [7:0] car_lo_reg;
  logic [7:0] gen_reg [8];
  logic [7:0] cal_temp_reg;
  logic synth_entry;
  assign synth_entry = wr_at(tcr_pkg::IDX_OPMODE) & mode_ok &
                       (mode_w != cfg_reg.mode) &
                       ((mode_w == tcr_pkg::MODE_TX_SYNTH) |
                        (mode_w == tcr_pkg::MODE_RX_SYNTH));

  function automatic logic [7:0] gen_idx(input int s);
    case (s)
      0: gen_idx = tcr_pkg::IDX_GAIN_REF;
      1: gen_idx = tcr_pkg::IDX_GAIN_TH1;
      2: gen_idx = tcr_pkg::IDX_GAIN_TH2;
      3: gen_idx = tcr_pkg::IDX_GAIN_TH3;
      4: gen_idx = tcr_pkg::IDX_HOP;
      5: gen_idx = tcr_pkg::IDX_REF_SEL;
      6: gen_idx = tcr_pkg::IDX_AMP_HP;
      default: gen_idx = tcr_pkg::IDX_LOOP_BW;
    endcase
  endfunction

  function automatic logic [7:0] gen_rst(input int s);
    case (s)
      2: gen_rst = tcr_pkg::RST_GAIN_TH2;
      3: gen_rst = tcr_pkg::RST_GAIN_TH3;
      default: gen_rst = tcr_pkg::RST_ZERO;
    endcase
  endfunction

  logic [7:0] quiet_bw_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg.mode <= tcr_pkg::RST_MODE;
      cfg_reg.keying_select <= tcr_pkg::KEY_FSK;
      cfg_reg.pulse_shaping_select <= 2'h0;
      cfg_reg.rate_divider_word <= {tcr_pkg::RST_RATE_HI,
                                    tcr_pkg::RST_RATE_LO};
      cfg_reg.rate_divider_fraction <= tcr_pkg::RST_FRACTION;
      cfg_reg.deviation <= {tcr_pkg::RST_DEV_HI, tcr_pkg::RST_DEV_LO};
      cfg_reg.pin_route_one <= tcr_pkg::RST_ZERO;
      cfg_reg.pin_route_two <= tcr_pkg::RST_ZERO;
      cfg_reg.carrier_active <= {tcr_pkg::RST_CARRIER_HI,
                                 tcr_pkg::RST_CARRIER_MID,
                                 tcr_pkg::RST_ZERO};
    end else begin
      if (wr_at(tcr_pkg::IDX_OPMODE)) begin
        if (mode_ok) begin
          cfg_reg.mode <= mode_w;
        end
        if (key_ok & shape_ok) begin
          cfg_reg.keying_select <= key_w;
          cfg_reg.pulse_shaping_select <= shape_w;
        end
      end
      // Divider word and fraction feed the rate generator
      if (wr_at(tcr_pkg::IDX_RATE_HI)) begin
        cfg_reg.rate_divider_word[15:8] <= wb;
      end
      if (wr_at(tcr_pkg::IDX_RATE_LO)) begin
        cfg_reg.rate_divider_word[7:0] <= wb;
      end
      if (wr_at(tcr_pkg::IDX_FRACTION)) begin
        cfg_reg.rate_divider_fraction <= wb[tcr_pkg::FRAC_W-1:0];
      end
      if (wr_at(tcr_pkg::IDX_DEV_HI)) begin
        cfg_reg.deviation[13:8] <= wb[tcr_pkg::DEV_HI_W-1:0];
      end
      if (wr_at(tcr_pkg::IDX_DEV_LO)) begin
        cfg_reg.deviation[7:0] <= wb;
      end
      if (wr_at(tcr_pkg::IDX_PIN_ONE)) begin
        cfg_reg.pin_route_one <= wb;
      end
      if (wr_at(tcr_pkg::IDX_PIN_TWO)) begin
        cfg_reg.pin_route_two <= wb;
      end
      if (synth_entry | radio.rx_restart_pulse) begin
        cfg_reg.carrier_active <= {car_hi_reg, car_mid_reg,
                                   car_lo_reg};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      car_hi_reg <= tcr_pkg::RST_CARRIER_HI;
      car_mid_reg <= tcr_pkg::RST_CARRIER_MID;
      car_lo_reg <= tcr_pkg::RST_ZERO;
      quiet_bw_reg <= tcr_pkg::RST_QUIET_BW;
      for (int s = 0; s < 8; s++) begin
        gen_reg[s] <= gen_rst(s);
      end
    end else begin
      if (wr_at(tcr_pkg::IDX_CARRIER_HI)) begin
        car_hi_reg <= wb;
      end
      if (wr_at(tcr_pkg::IDX_CARRIER_MID)) begin
        car_mid_reg <= wb;
      end
      if (wr_at(tcr_pkg::IDX_CARRIER_LO)) begin
        car_lo_reg <= wb;
      end
      if (wr_at(tcr_pkg::IDX_QUIET_BW)) begin
        quiet_bw_reg <= wb;
      end
      for (int s = 0; s < 8; s++) begin
        if (wr_at(gen_idx(s))) begin
          gen_reg[s] <= wb;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_temp_reg <= tcr_pkg::RST_ZERO;
    end else if (radio.cal_done_pulse) begin
      cal_temp_reg <= radio.cal_temp;
    end
  end

  // ----------------------------------------
  // Flags and interrupts
  // ----------------------------------------
  logic lock_reg;
  logic low_bat_reg;
  logic timeout_reg;
  logic rssi_reg;
  logic overrun_reg;
  logic [tcr_pkg::EV_W-1:0] ev_status_reg;
  logic [tcr_pkg::EV_W-1:0] ev_enable_reg;
  logic [tcr_pkg::EV_W-1:0] ev_set;
  logic [tcr_pkg::EV_W-1:0] ev_clr;
  logic [7:0] f1_clr;
  logic [7:0] f2_clr;
  assign f1_clr = wr_at(tcr_pkg::IDX_FLAGS_ONE) ? wb : 8'h00;
  assign f2_clr = wr_at(tcr_pkg::IDX_FLAGS_TWO) ? wb : 8'h00;
  assign ev_clr = wr_at(tcr_pkg::IDX_EV_CLEAR) ?
                  wb[tcr_pkg::EV_W-1:0] : '0;
  always_comb begin
    ev_set = '0;
    ev_set[tcr_pkg::EV_OVERRUN] = push_req & fifo_full;
    ev_set[tcr_pkg::EV_UNDERRUN] = pop_req & fifo_empty;
    ev_set[tcr_pkg::EV_TIMEOUT] = radio.timeout_pulse;
    ev_set[tcr_pkg::EV_RSSI] = radio.rssi_hit_pulse;
    ev_set[tcr_pkg::EV_LOW_BAT] = radio.low_battery & ~low_bat_reg;
    ev_set[tcr_pkg::EV_CAL_DONE] = radio.cal_done_pulse;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= 1'b0;
      low_bat_reg <= 1'b0;
      timeout_reg <= 1'b0;
      rssi_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      lock_reg <= radio.synth_locked;
      low_bat_reg <= radio.low_battery;
      timeout_reg <= radio.timeout_pulse |
                     (timeout_reg & ~f1_clr[tcr_pkg::F1_TIMEOUT]);
      rssi_reg <= radio.rssi_hit_pulse |
                  (rssi_reg & ~f1_clr[tcr_pkg::F1_RSSI]);
      overrun_reg <= ev_set[tcr_pkg::EV_OVERRUN] |
                     (overrun_reg & ~f2_clr[tcr_pkg::F2_OVERRUN]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_status_reg <= '0;
      ev_enable_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      ev_status_reg <= ev_set | (ev_status_reg & ~ev_clr);
      if (wr_at(tcr_pkg::IDX_EV_ENABLE)) begin
        ev_enable_reg <= wb[tcr_pkg::EV_W-1:0];
      end
      irq_reg <= |(ev_status_reg & ev_enable_reg);
    end
  end

  // ----------------------------------------
  // Read mux and APB answer
  // ----------------------------------------
  logic [7:0] rmux;
  logic [7:0] f1_val;
  logic [7:0] f2_val;
  always_comb begin
    f1_val = 8'h00;
    f1_val[tcr_pkg::F1_LOCK] = lock_reg;
    f1_val[tcr_pkg::F1_RSSI] = rssi_reg;
    f1_val[tcr_pkg::F1_TIMEOUT] = timeout_reg;
    f2_val = 8'h00;
    f2_val[tcr_pkg::F2_FULL] = fifo_full;
    f2_val[tcr_pkg::F2_EMPTY] = fifo_empty;
    f2_val[tcr_pkg::F2_OVERRUN] = overrun_reg;
    f2_val[tcr_pkg::F2_LOW_BAT] = low_bat_reg;
  end

  always_comb begin
    rmux = 8'h00;
    case (idx)
      tcr_pkg::IDX_FIFO: rmux = fifo_empty ? 8'h00 : fifo_mem[rptr_reg];
      tcr_pkg::IDX_OPMODE: rmux = {1'b0, cfg_reg.keying_select,
                                   cfg_reg.pulse_shaping_select,
                                   cfg_reg.mode};
      tcr_pkg::IDX_RATE_HI: rmux = cfg_reg.rate_divider_word[15:8];
      tcr_pkg::IDX_RATE_LO: rmux = cfg_reg.rate_divider_word[7:0];
      tcr_pkg::IDX_DEV_HI: rmux = {2'h0, cfg_reg.deviation[13:8]};
      tcr_pkg::IDX_DEV_LO: rmux = cfg_reg.deviation[7:0];
      tcr_pkg::IDX_CARRIER_HI: rmux = car_hi_reg;
      tcr_pkg::IDX_CARRIER_MID: rmux = car_mid_reg;
      tcr_pkg::IDX_CARRIER_LO: rmux = car_lo_reg;
      tcr_pkg::IDX_FLAGS_ONE: rmux = f1_val;
      tcr_pkg::IDX_FLAGS_TWO: rmux = f2_val;
      tcr_pkg::IDX_PIN_ONE: rmux = cfg_reg.pin_route_one;
      tcr_pkg::IDX_PIN_TWO: rmux = cfg_reg.pin_route_two;
      tcr_pkg::IDX_REVISION: rmux = REVISION;
      tcr_pkg::IDX_QUIET_BW: rmux = quiet_bw_reg;
      tcr_pkg::IDX_CAL_TEMP: rmux = cal_temp_reg;
      tcr_pkg::IDX_FRACTION: rmux = {4'h0, cfg_reg.rate_divider_fraction};
      tcr_pkg::IDX_EV_STATUS: rmux = {2'h0, ev_status_reg};
      tcr_pkg::IDX_EV_ENABLE: rmux = {2'h0, ev_enable_reg};
      default: begin
        for (int s = 0; s < 8; s++) begin
          if (idx == gen_idx(s)) begin
            rmux = gen_reg[s];
          end
        end
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel & penable & ~pready) begin
      pready <= 1'b1;
      pslverr <= ~aligned | ~is_mapped(idx);
      prdata <= {24'h000000, (pwrite | ~aligned) ? 8'h00 : rmux};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

/* hw/tcr_pkg.sv */
// Constants, field layouts and carrier types of the transceiver register bank
package tcr_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // ----------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------
  localparam logic [7:0] IDX_FIFO = 8'h00;
  localparam logic [7:0] IDX_OPMODE = 8'h01;
  localparam logic [7:0] IDX_RATE_HI = 8'h02;
  localparam logic [7:0] IDX_RATE_LO = 8'h03;
  localparam logic [7:0] IDX_DEV_HI = 8'h04;
  localparam logic [7:0] IDX_DEV_LO = 8'h05;
  localparam logic [7:0] IDX_CARRIER_HI = 8'h06;
  localparam logic [7:0] IDX_CARRIER_MID = 8'h07;
  localparam logic [7:0] IDX_CARRIER_LO = 8'h08;
  localparam logic [7:0] IDX_FLAGS_ONE = 8'h3E;
  localparam logic [7:0] IDX_FLAGS_TWO = 8'h3F;
  localparam logic [7:0] IDX_PIN_ONE = 8'h40;
  localparam logic [7:0] IDX_PIN_TWO = 8'h41;
  localparam logic [7:0] IDX_REVISION = 8'h42;
  localparam logic [7:0] IDX_GAIN_REF = 8'h43;
  localparam logic [7:0] IDX_GAIN_TH1 = 8'h44;
  localparam logic [7:0] IDX_GAIN_TH2 = 8'h45;
  localparam logic [7:0] IDX_GAIN_TH3 = 8'h46;
  localparam logic [7:0] IDX_HOP = 8'h4B;
  localparam logic [7:0] IDX_REF_SEL = 8'h58;
  localparam logic [7:0] IDX_AMP_HP = 8'h5A;
  localparam logic [7:0] IDX_LOOP_BW = 8'h5C;
  localparam logic [7:0] IDX_QUIET_BW = 8'h5E;
  localparam logic [7:0] IDX_CAL_TEMP = 8'h6C;
  localparam logic [7:0] IDX_FRACTION = 8'h70;
  localparam logic [7:0] IDX_EV_STATUS = 8'h7C;
  localparam logic [7:0] IDX_EV_CLEAR = 8'h7D;
  localparam logic [7:0] IDX_EV_ENABLE = 8'h7E;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [2:0] RST_MODE = 3'h1;
  localparam logic [7:0] RST_RATE_HI = 8'h1A;
  localparam logic [7:0] RST_RATE_LO = 8'h0B;
  localparam logic [5:0] RST_DEV_HI = 6'h00;
  localparam logic [7:0] RST_DEV_LO = 8'h52;
  localparam logic [7:0] RST_CARRIER_HI = 8'hE4;
  localparam logic [7:0] RST_CARRIER_MID = 8'hC0;
  localparam logic [7:0] RST_GAIN_TH2 = 8'h5B;
  localparam logic [7:0] RST_GAIN_TH3 = 8'hDB;
  localparam logic [7:0] RST_QUIET_BW = 8'hD0;
  localparam logic [3:0] RST_FRACTION = 4'h0;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MODE_LSB = 0;
  localparam int SHAPE_LSB = 3;
  localparam int KEY_LSB = 5;
  localparam int DEV_HI_W = 6;
  localparam int FRAC_W = 4;
  localparam int F1_LOCK = 7;
  localparam int F1_RSSI = 3;
  localparam int F1_TIMEOUT = 2;
  localparam int F2_FULL = 7;
  localparam int F2_EMPTY = 6;
  localparam int F2_OVERRUN = 4;
  localparam int F2_LOW_BAT = 0;

  // ----------------------------------------
  // Mode, keying and shaping codes
  // ----------------------------------------
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_TX_SYNTH = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX_SYNTH = 3'h4;
  localparam logic [2:0] MODE_RX = 3'h5;
  localparam logic [1:0] KEY_FSK = 2'h0;
  localparam logic [1:0] KEY_OOK = 2'h1;
  localparam logic [1:0] SHAPE_RSVD_OOK = 2'h3;

  // ----------------------------------------
  // Event bits of the interrupt registers
  // ----------------------------------------
  localparam int EV_W = 6;
  localparam int EV_OVERRUN = 0;
  localparam int EV_UNDERRUN = 1;
  localparam int EV_TIMEOUT = 2;
  localparam int EV_RSSI = 3;
  localparam int EV_LOW_BAT = 4;
  localparam int EV_CAL_DONE = 5;

  // Arbitrary neutral revision code
  localparam logic [7:0] REVISION_DEFAULT = 8'hA5;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] keying_select;
    logic [1:0] pulse_shaping_select;
    logic [15:0] rate_divider_word;
    logic [3:0] rate_divider_fraction;
    logic [13:0] deviation;
    logic [7:0] pin_route_one;
    logic [7:0] pin_route_two;
    logic [23:0] carrier_active;
  } tcr_cfg_s;

  typedef struct packed {
    logic synth_locked;
    logic timeout_pulse;
    logic rssi_hit_pulse;
    logic low_battery;
    logic cal_done_pulse;
    logic rx_restart_pulse;
    logic [7:0] cal_temp;
  } tcr_radio_s;

endpackage

/* test/tcr_regs_assertions.sv */
// Port assertions of the transceiver register bank
`timescale 1ns/1ps
module tcr_regs_chk #(
  parameter logic [7:0] REVISION = tcr_pkg::REVISION_DEFAULT
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcr_pkg::ADDR_W-1:0] paddr,
  input wire logic [tcr_pkg::DATA_W-1:0] pwdata,
  input wire logic [tcr_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Radio side
  input wire tcr_pkg::tcr_radio_s radio,
  input wire logic radio_push,
  input wire logic [7:0] radio_wdata,
  input wire logic radio_pop,
  input wire logic [7:0] radio_rdata_reg,
  // Configuration and interrupt
  input wire tcr_pkg::tcr_cfg_s cfg_reg,
  input wire logic irq_reg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic done;
  logic wr;
  assign done = psel && penable && pready;
  assign wr = done && pwrite;
  AST_MODE_LEGAL: assert property (
    cfg_reg.mode < 3'h6) else $error("reserved mode code held");
  AST_MODE_WRITE: assert property (
    wr && paddr == 10'h004 && pwdata[2:0] < 3'h6
    |=> cfg_reg.mode == $past(pwdata[2:0])) else $error("mode not taken");
  AST_KEY_LEGAL: assert property (
    cfg_reg.keying_select < 2'h2) else $error("reserved keying held");
  AST_OOK_SHAPE: assert property (
    !(cfg_reg.keying_select == tcr_pkg::KEY_OOK &&
      cfg_reg.pulse_shaping_select == tcr_pkg::SHAPE_RSVD_OOK))
    else $error("reserved on-off shaping held");
  AST_RESET_VAL: assert property (
    $rose(presetn) |-> cfg_reg.mode == 3'h1 &&
    cfg_reg.rate_divider_word == 16'h1A0B && cfg_reg.deviation == 14'h0052)
    else $error("wrong value after reset");
  AST_CARRIER_HOLD: assert property (
    $changed(cfg_reg.carrier_active) |-> $past(wr) ||
    $past(radio.rx_restart_pulse)) else $error("carrier changed alone");
  AST_REV_READ: assert property (
    done && !pwrite && paddr == 10'h108 |-> !pslverr &&
    prdata == {24'h000000, REVISION}) else $error("bad revision read");
  AST_UPPER_ZERO: assert property (
    pready |-> prdata[31:8] == 24'h000000) else $error("upper bits set");
  AST_FRAC_WRITE: assert property (
    wr && paddr == 10'h1C0 |=>
    cfg_reg.rate_divider_fraction == $past(pwdata[3:0]))
    else $error("fraction not taken");
  AST_DEV_WRITE: assert property (
    wr && paddr == 10'h010 |=> cfg_reg.deviation[13:8] == $past(pwdata[5:0]))
    else $error("deviation high not taken");
endmodule

bind tcr_regs tcr_regs_chk #(.REVISION(REVISION)) u_tcr_regs_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .radio(radio),
  .radio_push(radio_push), .radio_wdata(radio_wdata),
  .radio_pop(radio_pop), .radio_rdata_reg(radio_rdata_reg),
  .cfg_reg(cfg_reg), .irq_reg(irq_reg));

/* test/tcr_regs_tb.sv */
// Self-checking bench of the transceiver register bank
`timescale 1ns/1ps
module tcr_regs_tb;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tcr_pkg::tcr_radio_s radio = '0;
  logic radio_push = 1'h0;
  logic [7:0] radio_wdata = 8'h00;
  logic radio_pop = 1'h0;
  logic [7:0] radio_rdata_reg;
  tcr_pkg::tcr_cfg_s cfg_reg;
  logic irq_reg;
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic er;
  logic [2:0] m_exp;
  logic [3:0] ks_exp;
  logic [15:0] rt [12] = '{16'h0101, 16'h021A, 16'h030B, 16'h0400,
    16'h0552, 16'h42A5, 16'h455B, 16'h46DB, 16'h5ED0, 16'h3F40,
    16'h7000, 16'h4000};

  always #5 pclk = ~pclk;

  tcr_regs u_tcr_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .radio(radio),
    .radio_push(radio_push), .radio_wdata(radio_wdata),
    .radio_pop(radio_pop), .radio_rdata_reg(radio_rdata_reg),
    .cfg_reg(cfg_reg), .irq_reg(irq_reg));

  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // APB transfer, released right after the completion edge
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    penable <= 1'h0;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    if (pready !== 1'h1) begin
      err_total++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'h1, {i, 2'h0}, d);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    xfer(1'h0, {i, 2'h0}, 8'h00);
    chk({er, rd}, {25'h0, e});
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rt[i]) rdc(rt[i][15:8], rt[i][7:0]);
    chk(cfg_reg.carrier_active, 24'hE4C000);
    $display("reset values done");
    wr(8'h06, 8'h12);
    chk(cfg_reg.carrier_active, 24'hE4C000);
    m_exp = 3'h1;
    for (int m = 0; m < 8; m++) begin
      wr(8'h01, {5'h10, m[2:0]});
      if (m < 6) m_exp = m[2:0];
      rdc(8'h01, {5'h00, m_exp});
      chk(cfg_reg.mode, m_exp);
    end
    chk(cfg_reg.carrier_active, 24'h12C000);
    ks_exp = 4'h0;
    for (int k = 0; k < 16; k++) begin
      wr(8'h01, {1'h0, k[3:0], 3'h5});
      if (k < 7) ks_exp = k[3:0];
      rdc(8'h01, {1'h0, ks_exp, 3'h5});
      chk({cfg_reg.keying_select, cfg_reg.pulse_shaping_select}, ks_exp);
    end
    $display("mode codes done");
    radio_wdata <= 8'h77;
    radio_push <= 1'h1;
    @(posedge pclk);
    radio_push <= 1'h0;
    wr(8'h00, 8'h99);
    wr(8'h01, 8'h03);
    rdc(8'h00, 8'h77);
    radio_pop <= 1'h1;
    @(posedge pclk);
    radio_pop <= 1'h0;
    @(posedge pclk);
    chk(radio_rdata_reg, 8'h77);
    rdc(8'h3F, 8'h40);
    wr(8'h01, 8'h01);
    wr(8'h00, 8'h3C);
    wr(8'h00, 8'hC3);
    rdc(8'h00, 8'h3C);
    rdc(8'h00, 8'hC3);
    rdc(8'h00, 8'h00);
    $display("data port done");
    wr(8'h7E, 8'h04);
    radio.timeout_pulse <= 1'h1;
    @(posedge pclk);
    radio.timeout_pulse <= 1'h0;
    repeat (2) @(posedge pclk);
    chk(irq_reg, 1'h1);
    rdc(8'h3E, 8'h04);
    rdc(8'h7C, 8'h06);
    wr(8'h7D, 8'h06);
    rdc(8'h7C, 8'h00);
    chk(irq_reg, 1'h0);
    wr(8'h3E, 8'h04);
    rdc(8'h3E, 8'h00);
    radio.rssi_hit_pulse <= 1'h1;
    radio.cal_temp <= 8'h5A;
    radio.cal_done_pulse <= 1'h1;
    @(posedge pclk);
    radio.rssi_hit_pulse <= 1'h0;
    radio.cal_done_pulse <= 1'h0;
    repeat (2) @(posedge pclk);
    chk(irq_reg, 1'h0);
    rdc(8'h3E, 8'h08);
    wr(8'h6C, 8'h00);
    rdc(8'h6C, 8'h5A);
    $display("events done");
    wr(8'h42, 8'h00);
    chk(er, 1'h0);
    rdc(8'h42, 8'hA5);
    xfer(1'h1, 10'h140, 8'hFF);
    chk(er, 1'h1);
    xfer(1'h0, 10'h009, 8'h00);
    chk({er, rd}, 33'h100000000);
    wr(8'h70, 8'hFF);
    rdc(8'h70, 8'h0F);
    wr(8'h04, 8'hFF);
    rdc(8'h04, 8'h3F);
    wr(8'h02, 8'h12);
    wr(8'h03, 8'h34);
    @(posedge pclk);
    chk({cfg_reg.rate_divider_word, cfg_reg.rate_divider_fraction},
      20'h1234F);
    chk(cfg_reg.deviation, 14'h3F52);
    wr(8'h40, 8'hA5);
    wr(8'h41, 8'h5A);
    @(posedge pclk);
    chk({cfg_reg.pin_route_one, cfg_reg.pin_route_two}, 16'hA55A);
    wr(8'h07, 8'h34);
    radio.rx_restart_pulse <= 1'h1;
    @(posedge pclk);
    radio.rx_restart_pulse <= 1'h0;
    @(posedge pclk);
    chk(cfg_reg.carrier_active, 24'h123400);
    for (int i = 0; i < 17; i++) wr(8'h00, i[7:0]);
    rdc(8'h3F, 8'h90);
    rdc(8'h7C, 8'h29);
    wr(8'h3F, 8'h10);
    rdc(8'h3F, 8'h80);
    $display("fields done");
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    chk(cfg_reg.mode, 3'h1);
    chk(cfg_reg.carrier_active, 24'hE4C000);
    rdc(8'h02, 8'h1A);
    $display("second reset done");
    wrap_up();
  end
endmodule
